// >>> logic/bscan_cell_chain.sv
// boundary-scan cell chain: capture, shift toward bit 0, update latches
// assumes strobes are one-cycle enables on the core clock
`timescale 1ns/10ps

module bscan_cell_chain #(
    parameter int LEN = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // strobes
    input wire logic capEn,
    input wire logic shEn,
    input wire logic updEn,
    // serial and parallel data
    input wire logic sdi,
    input wire logic [LEN-1:0] parIn,
    output logic sdo,
    output logic [LEN-1:0] latch
);
    logic [LEN-1:0] stage;

    assign sdo = stage[0];

    for (genvar i = 0; i < LEN; i++) begin : g_cell
        // top cell takes tdi so the first bit in ends at bit 0
        logic nextBit;
        assign nextBit = (i == LEN - 1) ? sdi : stage[(i + 1) % LEN];
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                stage[i] <= 1'h0;
            end else if (capEn) begin
                stage[i] <= parIn[i];
            end else if (shEn) begin
                stage[i] <= nextBit;
            end
        end
        // latches survive instruction changes; extest shows them at once
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                latch[i] <= 1'h0;
            end else if (updEn) begin
                latch[i] <= stage[i];
            end
        end
    end
endmodule

// >>> logic/bscan_tap.sv
// boundary-scan test port: tap sequencer, instruction decode, data registers
// assumes tck/tms/tdi/pins are asynchronous; core signals share clk
`timescale 1ns/10ps
`include "bscan_map.svh"
// Operation
// - four-bit instruction register, sixteen opcodes
// - least significant bit shifts first, in and out
// - EXTEST: chain captures pins, shifts, drives outputs
// - EXTEST drives existing latch contents immediately
// - chain covers pull, control, data, analog interface
// - IDCODE 32-bit, default after power-up
// - IDCODE capture loads value, shift moves out
// - identification holds version, part, maker fields
// - SAMPLE/PRELOAD updates latches, pins undisturbed
// - reset opcode selects one-bit register, tap untouched
// - reset register one holds device reset, unlatched
// - reset persists for fuse-selected time-out after release
// - no HIGHZ; reset floats tri-state outputs, except under EXTEST, where the latches keep driving
// - external reset pin low also resets device
// - BYPASS selects one-stage register
// - bypass loads zero at capture
// - port enabled by fuse and clear disable bit
// - works only with core clk running, tck below a third of clk
module bscan_tap
    import bscan_pkg::*;
#(
    parameter int NUM_PINS = 8,
    parameter int ANA_CTRL = 2,
    parameter int ANA_OBS = 2,
    parameter logic [3:0] ID_VERSION = 4'h0,
    parameter logic [15:0] ID_PART = 16'h1234,   // arbitrary value
    parameter logic [10:0] ID_MFR = 11'h055,     // arbitrary value
    parameter int TIMEOUT_FAST = 64,
    parameter int TIMEOUT_SLOW = 4096
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe,
    // enables and reset time-out select
    input wire logic tap_enable_fuse,
    input wire logic tap_disable_bit,
    input wire logic clockOptionSlow,
    // device reset
    input wire logic extResetN,
    output logic coreResetN,
    // core side of the port pins
    input wire logic [NUM_PINS-1:0] coreOut,
    input wire logic [NUM_PINS-1:0] coreOe,
    input wire logic [NUM_PINS-1:0] corePullEn,
    // pad side
    input wire logic [NUM_PINS-1:0] padIn,
    output logic [NUM_PINS-1:0] padOut,
    output logic [NUM_PINS-1:0] padOeOut,
    output logic [NUM_PINS-1:0] padPullEn,
    // digital/analog boundary
    input wire logic [ANA_CTRL-1:0] coreAnaCtrl,
    output logic [ANA_CTRL-1:0] anaCtrl,
    input wire logic [ANA_OBS-1:0] anaObs,
    // status
    output bscan_pkg::instr_t currentInstr
);
    localparam int PIN_CELLS = NUM_PINS * `CELLS_PER_PIN;
    localparam int CHAIN_LEN = PIN_CELLS + ANA_CTRL + ANA_OBS;
    localparam int TO_W = $clog2(TIMEOUT_SLOW + 1);

    logic [1:0] rstSync;
    logic rstN;
    logic [2:0] tckSync;
    logic [1:0] tmsSync;
    logic [1:0] tdiSync;
    logic [1:0] extRstSync;
    logic [NUM_PINS-1:0] padSync1;
    logic [NUM_PINS-1:0] padSync2;
    logic tckRise;
    logic tckFall;
    logic tapEn;
    tap_state_e state;
    tap_state_e next_state;
    instr_t irShift;
    instr_t instr;
    logic selExtest;
    logic selSample;
    logic selId;
    logic selRst;
    logic selBypass;
    logic selChain;
    logic [`ID_W-1:0] idValue;
    logic [`ID_W-1:0] idShift;
    logic bypassReg;
    logic rstReg;
    logic [TO_W-1:0] timeout;
    logic resetSrc;
    logic chainSdo;
    logic [CHAIN_LEN-1:0] chainPar;
    logic [CHAIN_LEN-1:0] latch;
    logic drCap;
    logic drShift;
    logic drUpd;

    // reset release through two stages
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'h1};
        end
    end
    assign rstN = rstSync[1];

    // pin synchronisers; edges read only past the first stage
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            tckSync <= 3'h0;
            tmsSync <= 2'h3;
            tdiSync <= 2'h3;
            extRstSync <= 2'h3;
            padSync1 <= '0;
            padSync2 <= '0;
        end else begin
            tckSync <= {tckSync[1:0], tck};
            tmsSync <= {tmsSync[0], tms};
            tdiSync <= {tdiSync[0], tdi};
            extRstSync <= {extRstSync[0], extResetN};
            padSync1 <= padIn;
            padSync2 <= padSync1;
        end
    end
    // tck only needs to be below a third of clk; core clock gating elsewhere
    // must leave clk running, since this logic has no clock of its own
    assign tckRise = tckSync[1] & ~tckSync[2];
    assign tckFall = ~tckSync[1] & tckSync[2];
    assign tapEn = tap_enable_fuse & ~tap_disable_bit;

    // tap sequencer
    always_comb begin
        case (state)
            TLR: next_state = tmsSync[1] ? TLR : RTI;
            RTI: next_state = tmsSync[1] ? SEL_DR : RTI;
            SEL_DR: next_state = tmsSync[1] ? SEL_IR : CAP_DR;
            CAP_DR: next_state = tmsSync[1] ? EX1_DR : SH_DR;
            SH_DR: next_state = tmsSync[1] ? EX1_DR : SH_DR;
            EX1_DR: next_state = tmsSync[1] ? UPD_DR : PAU_DR;
            PAU_DR: next_state = tmsSync[1] ? EX2_DR : PAU_DR;
            EX2_DR: next_state = tmsSync[1] ? UPD_DR : SH_DR;
            UPD_DR: next_state = tmsSync[1] ? SEL_DR : RTI;
            SEL_IR: next_state = tmsSync[1] ? TLR : CAP_IR;
            CAP_IR: next_state = tmsSync[1] ? EX1_IR : SH_IR;
            SH_IR: next_state = tmsSync[1] ? EX1_IR : SH_IR;
            EX1_IR: next_state = tmsSync[1] ? UPD_IR : PAU_IR;
            PAU_IR: next_state = tmsSync[1] ? EX2_IR : PAU_IR;
            EX2_IR: next_state = tmsSync[1] ? UPD_IR : SH_IR;
            UPD_IR: next_state = tmsSync[1] ? SEL_DR : RTI;
            default: next_state = TLR;
        endcase
    end

    // the reset instruction never touches this state
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state <= TLR;
        end else if (!tapEn) begin
            state <= TLR;
        end else if (tckRise) begin
            state <= next_state;
        end
    end

    // instruction shift and latch
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irShift <= `IR_CAPTURE;
        end else if (tckRise && state == CAP_IR) begin
            irShift <= `IR_CAPTURE;
        end else if (tckRise && state == SH_IR) begin
            irShift <= {tdiSync[1], irShift[`IR_W-1:1]};
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            instr <= `OP_IDCODE;
        end else if (state == TLR) begin
            instr <= `OP_IDCODE;
        end else if (tckFall && state == UPD_IR) begin
            instr <= irShift;
        end
    end
    assign currentInstr = instr;

    // decode; anything else falls to bypass
    assign selExtest = instr == `OP_EXTEST;
    assign selSample = instr == `OP_SAMPLE;
    assign selId = instr == `OP_IDCODE;
    assign selRst = instr == `OP_DEVRST;
    assign selChain = selExtest | selSample;
    assign selBypass = ~(selChain | selId | selRst);

    assign drCap = tckRise && state == CAP_DR;
    assign drShift = tckRise && state == SH_DR;
    assign drUpd = tckFall && state == UPD_DR;

    // identification value
    always_comb begin
        idValue = '0;
        idValue[`ID_VER_LSB +: 4] = ID_VERSION;
        idValue[`ID_PART_LSB +: 16] = ID_PART;
        idValue[`ID_MFR_LSB +: 11] = ID_MFR;
        idValue[0] = `ID_FIXED_BIT;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            idShift <= '0;
        end else if (selId && drCap) begin
            idShift <= idValue;
        end else if (selId && drShift) begin
            idShift <= {tdiSync[1], idShift[`ID_W-1:1]};
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            bypassReg <= 1'h0;
        end else if (selBypass && drCap) begin
            bypassReg <= 1'h0;
        end else if (selBypass && drShift) begin
            bypassReg <= tdiSync[1];
        end
    end

    // unlatched: shifting a one in asserts reset with no update
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rstReg <= 1'h0;
        end else if (selRst && drShift) begin
            rstReg <= tdiSync[1];
        end
    end

    // boundary chain: per pin pull-disable, control, data, input; then analog
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        localparam int B = p * `CELLS_PER_PIN;
        assign chainPar[B + `CELL_PUD] = ~corePullEn[p];
        assign chainPar[B + `CELL_OE] = coreOe[p];
        assign chainPar[B + `CELL_OD] = coreOut[p];
        assign chainPar[B + `CELL_ID] = padSync2[p];
    end
    assign chainPar[PIN_CELLS +: ANA_CTRL] = coreAnaCtrl;
    assign chainPar[PIN_CELLS + ANA_CTRL +: ANA_OBS] = anaObs;

    bscan_cell_chain #(
        .LEN(CHAIN_LEN)
    ) u_chain (
        .clk(clk),
        .rstN(rstN),
        .capEn(selChain && drCap),
        .shEn(selChain && drShift),
        .updEn(selChain && drUpd),
        .sdi(tdiSync[1]),
        .parIn(chainPar),
        .sdo(chainSdo),
        .latch(latch)
    );

    // tdo moves on the falling tck edge, bit 0 of the selected path
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            tdo <= 1'h0;
            tdoOe <= 1'h0;
        end else if (!tapEn) begin
            tdo <= 1'h0;
            tdoOe <= 1'h0;
        end else if (tckFall) begin
            tdoOe <= state == SH_DR || state == SH_IR;
            if (state == SH_IR) begin
                tdo <= irShift[0];
            end else if (selId) begin
                tdo <= idShift[0];
            end else if (selRst) begin
                tdo <= rstReg;
            end else if (selChain) begin
                tdo <= chainSdo;
            end else begin
                tdo <= bypassReg;
            end
        end
    end

    // device reset with fuse-chosen hold-off after the last source drops
    assign resetSrc = rstReg | ~extRstSync[1];
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            timeout <= '0;
        end else if (resetSrc) begin
            timeout <= clockOptionSlow ? TO_W'(TIMEOUT_SLOW) : TO_W'(TIMEOUT_FAST);
        end else if (timeout != '0) begin
            timeout <= timeout - TO_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            coreResetN <= 1'h0;
        end else begin
            coreResetN <= ~(resetSrc || timeout != '0);
        end
    end

    // pads: extest shows latches as soon as loaded; reset floats outputs only when extest is not selected
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pad
        localparam int B = p * `CELLS_PER_PIN;
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                padOut[p] <= 1'h0;
                padOeOut[p] <= 1'h0;
                padPullEn[p] <= 1'h0;
            end else if (selExtest) begin
                padOut[p] <= latch[B + `CELL_OD];
                padOeOut[p] <= latch[B + `CELL_OE];
                padPullEn[p] <= ~latch[B + `CELL_PUD];
            end else if (!coreResetN) begin
                padOut[p] <= coreOut[p];
                padOeOut[p] <= 1'h0;
                padPullEn[p] <= 1'h0;
            end else begin
                padOut[p] <= coreOut[p];
                padOeOut[p] <= coreOe[p];
                padPullEn[p] <= corePullEn[p];
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            anaCtrl <= '0;
        end else if (selExtest) begin
            anaCtrl <= latch[PIN_CELLS +: ANA_CTRL];
        end else begin
            anaCtrl <= coreAnaCtrl;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    property p_ir_shift;
        tckRise && state == SH_IR && tapEn |=> irShift[`IR_W-1] == $past(tdiSync[1]);
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("ir msb not from tdi");

    property p_lsb_out;
        tckFall && tapEn && state == SH_DR && selBypass |=> tdo == $past(bypassReg);
    endproperty
    a_lsb_out: assert property (p_lsb_out) else $error("bypass bit not on tdo");

    property p_extest_drive;
        selExtest ##1 selExtest |-> padOeOut[0] == $past(latch[`CELL_OE]);
    endproperty
    a_extest_drive: assert property (p_extest_drive) else $error("extest latch not driven");

    property p_idle_idcode;
        state == TLR |=> instr == `OP_IDCODE;
    endproperty
    a_idle_idcode: assert property (p_idle_idcode) else $error("idcode not default");

    property p_id_capture;
        selId && drCap |=> idShift == idValue && idShift[0];
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("id not captured");

    property p_sample_quiet;
        !selExtest && coreResetN |=> padOeOut == $past(coreOe) && padOut == $past(coreOut);
    endproperty
    a_sample_quiet: assert property (p_sample_quiet) else $error("pins disturbed");

    property p_rst_now;
        $rose(rstReg) |=> !coreResetN;
    endproperty
    a_rst_now: assert property (p_rst_now) else $error("tap reset late");

    property p_rst_hold;
        $fell(resetSrc) |=> !coreResetN [*8];
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset time-out short");

    property p_float;
        !coreResetN && !selExtest |=> padOeOut == '0;
    endproperty
    a_float: assert property (p_float) else $error("outputs not floated");

    property p_ext_reset;
        !extRstSync[1] |=> !coreResetN;
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("pin reset ignored");

    property p_bypass_zero;
        selBypass && drCap |=> bypassReg == 1'h0;
    endproperty
    a_bypass_zero: assert property (p_bypass_zero) else $error("bypass not cleared");

    property p_disabled;
        !tapEn |=> !tdoOe && state == TLR;
    endproperty
    a_disabled: assert property (p_disabled) else $error("port active when off");

    c_extest: cover property (selExtest && drUpd);
    c_id_shift: cover property (selId && drShift ##[1:300] selId && drShift);
    c_tap_reset: cover property ($rose(rstReg) ##[1:1000] $rose(coreResetN));
    c_sample: cover property (selSample && drCap);
endmodule

// >>> shared/bscan_map.svh
// boundary-scan port constants: opcodes, widths, chain layout
// assumes inclusion by the package and the design modules only
`ifndef BSCAN_MAP_SVH
`define BSCAN_MAP_SVH

`define IR_W 4
`define OP_EXTEST 4'h0
`define OP_IDCODE 4'h1
`define OP_SAMPLE 4'h2
`define OP_DEVRST 4'hC
`define OP_BYPASS 4'hF
`define IR_CAPTURE 4'h1

`define ID_W 32
`define ID_VER_LSB 28
`define ID_PART_LSB 12
`define ID_MFR_LSB 1
`define ID_FIXED_BIT 1'h1

`define CELLS_PER_PIN 4
`define CELL_PUD 0
`define CELL_OE 1
`define CELL_OD 2
`define CELL_ID 3

`endif

// >>> shared/bscan_pkg.sv
// types shared by the boundary-scan port modules
// assumes bscan_map.svh sits beside it on the include path
`include "bscan_map.svh"

package bscan_pkg;
    typedef enum {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_e;
    typedef logic [`IR_W-1:0] instr_t;
endpackage

// >>> verif/bscan_ctrl_model.sv
// far-side test controller: drives tck/tms/tdi, samples tdo at each tck rise
// assumes the bench calls one task at a time; tck rests low between frames
`timescale 1ns/10ps

module bscan_ctrl_model (
    // test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdoOe,
    // shift enable seen high on every data bit of the last scan
    output logic oeAll
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        oeAll = 1'b1;
    end

    // one tck period; tdo is taken just before the rise
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #32;
        q = tdo;
        tck = 1'b1;
        #32;
        tck = 1'b0;
    endtask

    // five ones reach test-logic-reset from anywhere, then idle
    task automatic reset_tap();
        logic q;
        repeat (5) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
    endtask

    // from idle: shift n bits through the instruction or data path, back to idle
    task automatic scan(input logic isIr, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic q;
        #1.7;
        dout = '0;
        oeAll = 1'b1;
        pulse(1'b1, ~tdi, q);
        if (isIr) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
            oeAll = oeAll & tdoOe;
        end
        pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        // released data line must not keep its last value
        tdi = ~tdi;
    endtask
endmodule

// >>> verif/bscan_tap_tb.sv
// self-checking bench for bscan_tap, scanning through the controller model
// assumes bscan_pkg compiled first; ids below are arbitrary values
`timescale 1ns/10ps

module bscan_tap_tb;
    import bscan_pkg::*;
    localparam int TO_FAST = 8;
    localparam int TO_SLOW = 16;
    localparam logic [3:0] VER = 4'h3;
    localparam logic [15:0] PART = 16'hA5C3;  // arbitrary
    localparam logic [10:0] MFR = 11'h2B6;  // arbitrary
    typedef struct {string what; logic [63:0] exp; logic [63:0] mask;} note_s;
    logic clk, resetn, tck, tms, tdi, tdo, tdoOe, oeAll, fuse, dis, slow, extResetN, coreResetN;
    logic [7:0] coreOut, coreOe, corePullEn, padIn, padOut, padOeOut, padPullEn;
    logic [1:0] coreAnaCtrl, anaCtrl, anaObs;
    instr_t currentInstr;
    logic [63:0] seen, o, d, pre, capE, capM;
    note_s q[$];
    note_s cur;
    event shown;
    int fails = 0;
    int totalChecks = 0;
    int cnt, to;
    int unsigned rnd;

    bscan_tap #(.TIMEOUT_FAST(TO_FAST), .TIMEOUT_SLOW(TO_SLOW), .ID_VERSION(VER),
                .ID_PART(PART), .ID_MFR(MFR)) dut (
        .clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe), .tap_enable_fuse(fuse), .tap_disable_bit(dis),
        .clockOptionSlow(slow), .extResetN(extResetN), .coreResetN(coreResetN),
        .coreOut(coreOut), .coreOe(coreOe), .corePullEn(corePullEn), .padIn(padIn),
        .padOut(padOut), .padOeOut(padOeOut), .padPullEn(padPullEn),
        .coreAnaCtrl(coreAnaCtrl), .anaCtrl(anaCtrl), .anaObs(anaObs),
        .currentInstr(currentInstr));

    bscan_ctrl_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe),
                          .oeAll(oeAll));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic note(input string what, input logic [63:0] exp, input logic [63:0] mask);
        q.push_back('{what, exp, mask});
    endtask

    task automatic show(input logic [63:0] v);
        seen = v;
        ->shown;
        #0.1;
    endtask

    // oldest note against each result as it appears
    always @(shown) begin
        if (q.size() == 0) begin
            check("unnoted result", 64'h1, 64'h0);
        end else begin
            cur = q.pop_front();
            check(cur.what, seen & cur.mask, cur.exp & cur.mask);
        end
    end

    task automatic final_report();
        if (fails == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic ir(input logic [3:0] op);
        logic [63:0] r;
        note("ir capture", 64'h1, 64'hF);
        ctl.scan(1'b1, 4, {60'h0, op}, r);
        show(r);
    endtask

    // expected pad view {pull, oe, data} of a chain image
    function automatic logic [23:0] pins(input logic [63:0] c);
        logic [23:0] r;
        for (int p = 0; p < 8; p++) begin
            r[16+p] = ~c[4*p];
            r[8+p] = c[4*p+1];
            r[p] = c[4*p+2];
        end
        return r;
    endfunction

    initial begin
        resetn = 1'b0;
        fuse = 1'b1;
        dis = 1'b0;
        slow = 1'b0;
        extResetN = 1'b1;
        {coreOut, coreOe, corePullEn, padIn} = '0;
        {coreAnaCtrl, anaObs} = '0;
        rnd = $urandom(66451);
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        repeat (8) tick();
        note("instr at power-up", 64'h1, 64'hF);
        show(64'(currentInstr));
        ctl.reset_tap();
        note("idcode", {32'h0, VER, PART, MFR, 1'b1}, 64'hFFFF_FFFF);
        ctl.scan(1'b0, 32, {32'h0, $urandom}, o);
        show(o);
        note("shift enable", 64'h1, 64'h1);
        show(64'(oeAll));
        for (int op = 0; op < 16; op++) begin
            if (op inside {0, 1, 2, 12}) continue;
            ir(op[3:0]);
            note("instr", 64'(op), 64'hF);
            show(64'(currentInstr));
            d = {56'h0, 8'($urandom)};
            note("bypass path", {d[62:0], 1'b0}, 64'h1FF);
            ctl.scan(1'b0, 9, d, o);
            show(o);
        end
        tick();
        {coreOut, coreOe, corePullEn} = 24'($urandom);
        {padIn, coreAnaCtrl, anaObs} = 12'($urandom);
        ir(4'h2);
        capE = '0;
        capM = 64'hF_FFFF_FFFF;
        for (int p = 0; p < 8; p++) begin
            capE[4*p+:4] = {padIn[p], coreOut[p], coreOe[p], ~corePullEn[p]};
        end
        capE[35:32] = {anaObs, coreAnaCtrl};
        pre = {28'h0, $urandom, 4'($urandom)};
        note("sampled pins", capE, capM);
        ctl.scan(1'b0, 36, pre, o);
        show(o);
        repeat (3) tick();
        note("pads undisturbed", {corePullEn, coreOe, coreOut}, 64'hFF_FFFF);
        show({padPullEn, padOeOut, padOut});
        // safe values went in by preload before the first extest
        ir(4'h0);
        repeat (3) tick();
        note("latch on load", pins(pre), 64'hFF_FFFF);
        show({padPullEn, padOeOut, padOut});
        note("analog on load", pre[33:32], 64'h3);
        show(anaCtrl);
        pre = {28'h0, $urandom, 4'($urandom)};
        note("extest capture", capE, capM);
        ctl.scan(1'b0, 36, pre, o);
        show(o);
        repeat (3) tick();
        note("extest update", pins(pre), 64'hFF_FFFF);
        show({padPullEn, padOeOut, padOut});
        ir(4'hC);
        ctl.scan(1'b0, 1, 64'h1, o);
        repeat (2) tick();
        note("reset held", 64'h0, 64'h1);
        show(64'(coreResetN));
        note("outputs floated", 64'h0, 64'hFFFF);
        show({padPullEn, padOeOut});
        note("tap kept", 64'hC, 64'hF);
        show(64'(currentInstr));
        ctl.scan(1'b0, 1, 64'h0, o);
        note("one-bit reset path", 64'h1, 64'h1);
        show(o);
        note("reset released", 64'h1, 64'h1);
        show(64'(coreResetN));
        for (int s = 0; s < 2; s++) begin
            tick();
            slow = s[0];
            extResetN = 1'b0;
            repeat (6) tick();
            note("pin reset", 64'h0, 64'h1);
            show(64'(coreResetN));
            tick();
            extResetN = 1'b1;
            cnt = 0;
            while (coreResetN !== 1'b1 && cnt < 200) begin
                tick();
                cnt++;
            end
            to = s ? TO_SLOW : TO_FAST;
            note("time-out length", 64'h1, 64'h1);
            show(64'(cnt >= to && cnt <= to + 6));
        end
        ir(4'hF);
        for (int k = 0; k < 2; k++) begin
            tick();
            fuse = k[0];
            dis = k[0];
            repeat (4) tick();
            note("disabled capture", 64'h0, 64'hF);
            ctl.scan(1'b1, 4, 64'h2, o);
            show(o);
            note("disabled instr", 64'h1, 64'hF);
            show(64'(currentInstr));
            note("disabled oe", 64'h0, 64'h1);
            show(64'(oeAll));
        end
        final_report();
    end
endmodule
